// file: hw/vops_pkg.sv
// Package for the video output processing and sync block.
// Holds register map, field layout, stream carriers, timing counts and pattern codes.
package vops_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_FMT = 10'h002;
  localparam logic [9:0] IDX_HSE = 10'h036;
  localparam logic [9:0] IDX_LCTL = 10'h040;
  localparam logic [9:0] IDX_CCTL = 10'h041;
  localparam logic [9:0] IDX_BRI = 10'h042;
  localparam logic [9:0] IDX_CON = 10'h043;
  localparam logic [9:0] IDX_SAT = 10'h044;
  localparam logic [9:0] IDX_HUE = 10'h045;
  localparam logic [9:0] IDX_STAT = 10'h046;

  // Reset values
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam logic [7:0] RST_HSE = 8'h20;
  localparam logic [7:0] RST_LCTL = 8'h00;
  localparam logic [7:0] RST_CCTL = 8'h00;
  localparam logic [7:0] RST_BRI = 8'h00;
  localparam logic [7:0] RST_CON = 8'h80;
  localparam logic [7:0] RST_SAT = 8'h80;
  localparam logic [7:0] RST_HUE = 8'h00;

  // Output format fields
  localparam int FMT_PAT_LSB = 1;
  localparam int FMT_MODE_LSB = 3;
  localparam int FMT_LIN_BIT = 5;
  localparam int FMT_G28_BIT = 6;
  localparam logic [1:0] PAT_NORMAL = 2'h0;
  localparam logic [1:0] PAT_BLUE = 2'h1;
  localparam logic [1:0] PAT_BLACK = 2'h2;
  localparam logic [1:0] PAT_BARS = 2'h3;
  localparam logic [1:0] MODE_RGB15 = 2'h2;
  localparam logic [1:0] MODE_RGB16 = 2'h3;

  // Luma and chroma control fields
  localparam int LC_CORE_LSB = 0;
  localparam int LC_TRAP_BIT = 2;
  localparam int LC_LPF_BIT = 3;
  localparam int LC_PEAK_BIT = 4;
  localparam int LC_PSEL_BIT = 5;
  localparam int LC_PGAIN_LSB = 6;
  localparam int CC_CORE_LSB = 0;
  localparam int CC_CON_BIT = 2;

  // Levels
  localparam int Y_WHITE_CODE = 219;
  localparam int Y_OFFSET = 16;
  localparam int C_ZERO = 128;
  localparam int OUT_MIN = 1;
  localparam int OUT_MAX = 254;
  localparam int R5_MAX = 31;
  localparam int G6_MAX = 63;

  // Matrix weights scaled by 1024
  localparam int K_Y5 = 145;
  localparam int K_RCR = 199;
  localparam int K_GCR5 = 101;
  localparam int K_GCB5 = 49;
  localparam int K_BCB = 251;
  localparam int K_Y6 = 295;
  localparam int K_GCR6 = 206;
  localparam int K_GCB6 = 99;

  // Gamma figures
  localparam real GAM_KNEE = 0.0812;
  localparam real GAM_LIN_DIV = 4.5;
  localparam real GAM_OFS = 0.099;
  localparam real GAM_DIV = 1.099;
  localparam real GAM_22 = 2.2;
  localparam real GAM_28 = 2.8;

  // Sync timing counts in sample clock cycles
  localparam int FS_GAP_CYC = 5;
  localparam int HS_END_STEP = 2;

  // Pattern codes {Y, Cb, Cr}; bars from white to black
  localparam logic [7:0][23:0] BAR_CODES = {
    24'h108080, 24'h23d472, 24'h4164d4, 24'h54b8c6,
    24'h70483a, 24'h839c2c, 24'ha22c8e, 24'hb48080};
  localparam logic [23:0] BLUE_CODE = 24'h4bd988;
  localparam logic [23:0] BLACK_CODE = 24'h108080;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vops_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vops_apb_rsp_type;

  typedef struct packed {
    logic [9:0] luma;
    logic [7:0] chroma;
    logic cr_phase;
    logic blank;
    logic vbi;
    logic hsync_lead;
  } vops_vin_type;

  typedef struct packed {
    logic [15:0] pix;
    logic cr_phase;
    logic blank;
    logic vbi;
  } vops_vout_type;

  typedef struct packed {
    logic lead;
    logic blank;
    logic vbi;
    logic cph;
  } vops_qual_type;

  typedef enum logic [2:0] {
    VS_IDLE = 3'b000,
    VS_PRE = 3'b001,
    VS_ACT = 3'b010,
    VS_EDGE = 3'b011,
    VS_POST = 3'b100
  } vops_vs_type;

endpackage

// file: hw/vops_top.sv
// Video output processing and sync: luma and chroma adjust, YCbCr/RGB formatting,
// gamma, pattern generator, line/frame sync and field outputs, APB registers.
// Assumes the front end delivers separated samples and sync qualifiers on mclk.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module vops_top
  import vops_pkg::*;
#(
  parameter int RAW_BLACK = 64,
  parameter int RAW_WHITE = 940,
  parameter int LINE_CYC = 1716,
  parameter int FIELD_LINES = 262,
  parameter int EQ_END_LINE = 2,
  parameter int ACTIVE_START = 256,
  parameter int ACTIVE_CYC = 1440,
  parameter int BAR_W = 180,
  parameter int SERR_LOW_CYC = 256
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input vops_pkg::vops_apb_req_type apb_req,
  output vops_pkg::vops_apb_rsp_type apb_rsp,
  // Decoded stream and front-end status
  input vops_pkg::vops_vin_type vin,
  input wire logic src_locked,
  input wire logic std_pal,
  input wire logic sync_low,
  input wire logic eq_end,
  input wire logic field_known,
  input wire logic field_src,
  // Formatted stream, sync outputs and hue phase
  output vops_pkg::vops_vout_type vout,
  output logic line_sync_n,
  output logic frame_sync_n,
  output logic field_out,
  output logic [7:0] hue_phase
);
  import vops_pkg::*;

  localparam int QN = 7;
  localparam int SCALE = (Y_WHITE_CODE * 256) / (RAW_WHITE - RAW_BLACK);

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] hse;
    logic [7:0] lctl;
    logic [7:0] cctl;
    logic [7:0] bri;
    logic [7:0] con;
    logic [7:0] sat;
    logic [7:0] hue;
    logic [31:0] prdata;
    logic pslverr;
    logic [QN-1:0][3:0] q;
    logic [4:0][11:0] tap;
    logic [11:0] y2;
    logic [11:0] y3;
    logic [11:0] y4;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    logic [7:0] c4;
    logic [7:0] y5;
    logic [7:0] c5;
    logic [7:0] cb_h;
    logic [7:0] cr_h;
    logic [7:0] y6;
    logic [7:0] c6;
    logic [4:0] r6;
    logic [5:0] g6;
    logic [4:0] b6;
    logic [15:0] pix;
    logic [11:0] hcount;
    logic [9:0] lcount;
    logic hs_n;
    logic hs_prev;
    logic [8:0] hs_cnt;
    logic [11:0] acc;
    logic fld;
    logic vs_n;
    vops_vs_type vs;
    logic [2:0] vcnt;
  } vops_state_type;

  vops_state_type st_r;
  vops_state_type st_nxt;

  // Gamma tables built at elaboration
  logic [4:0] lut22_5 [32];
  logic [4:0] lut28_5 [32];
  logic [5:0] lut22_6 [64];
  logic [5:0] lut28_6 [64];

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_lut
      localparam real N6 = gi / 63.0;
      localparam int L22_6 = (N6 < GAM_KNEE) ? int'(63.0 * N6 / GAM_LIN_DIV) :
                             int'(63.0 * (((N6 + GAM_OFS) / GAM_DIV) ** GAM_22));
      localparam int L28_6 = int'(63.0 * (N6 ** GAM_28));
      assign lut22_6[gi] = 6'(L22_6);
      assign lut28_6[gi] = 6'(L28_6);
      if (gi < 32)
      begin : g_five
        localparam real N5 = gi / 31.0;
        localparam int L22_5 = (N5 < GAM_KNEE) ? int'(31.0 * N5 / GAM_LIN_DIV) :
                               int'(31.0 * (((N5 + GAM_OFS) / GAM_DIV) ** GAM_22));
        localparam int L28_5 = int'(31.0 * (N5 ** GAM_28));
        assign lut22_5[gi] = 5'(L22_5);
        assign lut28_5[gi] = 5'(L28_5);
      end
    end
  endgenerate

  function automatic int clampi(input int v, input int lo, input int hi);
    clampi = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic int absi(input int v);
    absi = (v < 0) ? -v : v;
  endfunction

  vops_qual_type qin;
  vops_qual_type qs;
  logic [9:0] idx;
  logic mapped;
  logic [31:0] rdval;
  logic int_lead;
  logic int_fstart;
  logic int_eq;
  logic fstart;
  logic eq_sel;
  logic hs_edge;
  logic [1:0] pat;
  logic [1:0] mode;
  logic [2:0] bar;
  logic [23:0] pcode;
  int y1, yf, pk, yc, yb, cd, ct, yy, cc, cbv, crv, ydd, cbd, crd, rv, gv, bv;

  always_comb
  begin
    y1 = 0;
    yf = 0;
    pk = 0;
    yc = 0;
    yb = 0;
    cd = 0;
    ct = 0;
    yy = 0;
    cc = 0;
    cbv = 0;
    crv = 0;
    ydd = 0;
    cbd = 0;
    crd = 0;
    rv = 0;
    gv = 0;
    bv = 0;
    st_nxt = st_r;
    pat = st_r.fmt[FMT_PAT_LSB +: 2];
    mode = st_r.fmt[FMT_MODE_LSB +: 2];

    // Register bus; zero wait states, data captured in setup phase
    idx = apb_req.paddr[11:2];
    mapped = 1'b1;
    rdval = 32'h0;
    case (idx)
      IDX_FMT: rdval = {24'h0, st_r.fmt};
      IDX_HSE: rdval = {24'h0, st_r.hse};
      IDX_LCTL: rdval = {24'h0, st_r.lctl};
      IDX_CCTL: rdval = {24'h0, st_r.cctl};
      IDX_BRI: rdval = {24'h0, st_r.bri};
      IDX_CON: rdval = {24'h0, st_r.con};
      IDX_SAT: rdval = {24'h0, st_r.sat};
      IDX_HUE: rdval = {24'h0, st_r.hue};
      IDX_STAT: rdval = {28'h0, src_locked, st_r.fld, ~st_r.vs_n, ~st_r.hs_n};
      default: mapped = 1'b0;
    endcase
    if (apb_req.psel && !apb_req.penable)
    begin
      st_nxt.prdata = rdval;
      st_nxt.pslverr = ~mapped;
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite)
    begin
      case (idx)
        IDX_FMT: st_nxt.fmt = apb_req.pwdata[7:0];
        IDX_HSE: st_nxt.hse = apb_req.pwdata[7:0];
        IDX_LCTL: st_nxt.lctl = apb_req.pwdata[7:0];
        IDX_CCTL: st_nxt.cctl = apb_req.pwdata[7:0];
        IDX_BRI: st_nxt.bri = apb_req.pwdata[7:0];
        IDX_CON: st_nxt.con = apb_req.pwdata[7:0];
        IDX_SAT: st_nxt.sat = apb_req.pwdata[7:0];
        IDX_HUE: st_nxt.hue = apb_req.pwdata[7:0];
        default: st_nxt.hue = st_r.hue;
      endcase
    end

    // Line timing; one counter serves both source and free-running timing
    int_lead = !src_locked && (st_r.hcount == 12'(LINE_CYC - 1));
    if ((src_locked && vin.hsync_lead) || (st_r.hcount == 12'(LINE_CYC - 1)))
      st_nxt.hcount = 12'h000;
    else
      st_nxt.hcount = st_r.hcount + 12'h001;
    if (int_lead)
      st_nxt.lcount = (st_r.lcount == 10'(FIELD_LINES - 1)) ? 10'h000 : st_r.lcount + 10'h001;
    int_fstart = int_lead && (st_r.lcount == 10'(FIELD_LINES - 1));
    int_eq = int_lead && (st_r.lcount == 10'(EQ_END_LINE));

    // Qualifiers enter with the first stage and shift alongside data
    qin.lead = src_locked ? vin.hsync_lead : int_lead;
    qin.blank = src_locked ? vin.blank :
                ((st_r.hcount < 12'(ACTIVE_START)) ||
                 (st_r.hcount >= 12'(ACTIVE_START + ACTIVE_CYC)));
    qin.vbi = src_locked & vin.vbi;
    qin.cph = vin.cr_phase;
    st_nxt.q = {st_r.q[QN-2:0], qin};

    // Stage 1: black removal and scaling; negatives kept
    y1 = ((int'(vin.luma) - RAW_BLACK) * SCALE) >>> 8;
    st_nxt.tap = {st_r.tap[3:0], 12'(y1)};
    st_nxt.c1 = vin.chroma;

    // Stage 2: trap or low-pass, then peaking
    yf = int'($signed(st_r.tap[1]));
    if (st_r.lctl[LC_TRAP_BIT])
      yf = std_pal ? (int'($signed(st_r.tap[0])) + int'($signed(st_r.tap[3]))) >>> 1 :
                     (int'($signed(st_r.tap[0])) + int'($signed(st_r.tap[2]))) >>> 1;
    else if (st_r.lctl[LC_LPF_BIT])
      yf = (int'($signed(st_r.tap[0])) + 2 * int'($signed(st_r.tap[1])) +
            int'($signed(st_r.tap[2]))) >>> 2;
    if (st_r.lctl[LC_PEAK_BIT])
    begin
      // Wider tap spacing moves the peak down to the subcarrier
      if (st_r.lctl[LC_PSEL_BIT])
        pk = 2 * int'($signed(st_r.tap[2])) - int'($signed(st_r.tap[0])) -
             int'($signed(st_r.tap[4]));
      else
        pk = 2 * int'($signed(st_r.tap[1])) - int'($signed(st_r.tap[0])) -
             int'($signed(st_r.tap[2]));
      yf = yf + ((pk * (int'(st_r.lctl[LC_PGAIN_LSB +: 2]) + 1)) >>> 3);
    end
    st_nxt.y2 = 12'(yf);
    st_nxt.c2 = st_r.c1;

    // Stage 3: coring around black and around zero colour
    yc = int'($signed(st_r.y2));
    if (absi(yc) <= int'(st_r.lctl[LC_CORE_LSB +: 2]))
      yc = 0;
    st_nxt.y3 = 12'(yc);
    st_nxt.c3 = st_r.c2;
    if (absi(int'(st_r.c2) - C_ZERO) <= int'(st_r.cctl[CC_CORE_LSB +: 2]))
      st_nxt.c3 = 8'(C_ZERO);

    // Stage 4: brightness, contrast, saturation
    yb = (((int'($signed(st_r.y3)) + int'($signed(st_r.bri))) * int'(st_r.con)) >>> 7)
         + Y_OFFSET;
    st_nxt.y4 = 12'(clampi(yb, -2048, 2047));
    cd = ((int'(st_r.c3) - C_ZERO) * int'(st_r.sat)) >>> 7;
    if (st_r.cctl[CC_CON_BIT])
      cd = (cd * int'(st_r.con)) >>> 7;
    st_nxt.c4 = 8'(clampi(cd + C_ZERO, 0, 255));

    // Stage 5: pattern insertion, clamp, blanking, chroma hold for 4:4:4
    qs = st_r.q[3];
    ct = int'(st_r.hcount) - ACTIVE_START;
    bar = (ct < 0) ? 3'h0 : 3'(clampi(ct / BAR_W, 0, 7));
    case (pat)
      PAT_BLUE: pcode = BLUE_CODE;
      PAT_BLACK: pcode = BLACK_CODE;
      PAT_BARS: pcode = BAR_CODES[bar];
      default: pcode = BLACK_CODE;
    endcase
    if (pat != PAT_NORMAL)
    begin
      yy = int'(pcode[23:16]);
      cc = qs.cph ? int'(pcode[7:0]) : int'(pcode[15:8]);
    end
    else
    begin
      yy = int'($signed(st_r.y4));
      cc = int'(st_r.c4);
    end
    yy = clampi(yy, OUT_MIN, OUT_MAX);
    cc = clampi(cc, OUT_MIN, OUT_MAX);
    if (qs.cph)
      st_nxt.cr_h = 8'(cc);
    else
      st_nxt.cb_h = 8'(cc);
    if (qs.blank && !qs.vbi)
    begin
      yy = Y_OFFSET;
      cc = C_ZERO;
    end
    st_nxt.y5 = 8'(yy);
    st_nxt.c5 = 8'(cc);

    // Stage 6: colour space conversion with held partner chroma
    qs = st_r.q[4];
    cbv = qs.cph ? int'(st_r.cb_h) : int'(st_r.c5);
    crv = qs.cph ? int'(st_r.c5) : int'(st_r.cr_h);
    ydd = int'(st_r.y5) - Y_OFFSET;
    cbd = cbv - C_ZERO;
    crd = crv - C_ZERO;
    rv = (K_Y5 * ydd + K_RCR * crd + 512) >>> 10;
    bv = (K_Y5 * ydd + K_BCB * cbd + 512) >>> 10;
    if (mode == MODE_RGB16)
      gv = clampi((K_Y6 * ydd - K_GCR6 * crd - K_GCB6 * cbd + 512) >>> 10, 0, G6_MAX);
    else
      gv = clampi((K_Y5 * ydd - K_GCR5 * crd - K_GCB5 * cbd + 512) >>> 10, 0, R5_MAX);
    st_nxt.r6 = 5'(clampi(rv, 0, R5_MAX));
    st_nxt.b6 = 5'(clampi(bv, 0, R5_MAX));
    st_nxt.g6 = 6'(gv);
    st_nxt.y6 = st_r.y5;
    st_nxt.c6 = st_r.c5;

    // Stage 7: gamma and packing
    qs = st_r.q[5];
    if (mode == MODE_RGB15 || mode == MODE_RGB16)
    begin
      rv = int'(st_r.r6);
      gv = int'(st_r.g6);
      bv = int'(st_r.b6);
      if (st_r.fmt[FMT_LIN_BIT])
      begin
        rv = st_r.fmt[FMT_G28_BIT] ? int'(lut28_5[st_r.r6]) : int'(lut22_5[st_r.r6]);
        bv = st_r.fmt[FMT_G28_BIT] ? int'(lut28_5[st_r.b6]) : int'(lut22_5[st_r.b6]);
        if (mode == MODE_RGB16)
          gv = st_r.fmt[FMT_G28_BIT] ? int'(lut28_6[st_r.g6]) : int'(lut22_6[st_r.g6]);
        else
          gv = st_r.fmt[FMT_G28_BIT] ? int'(lut28_5[st_r.g6[4:0]]) :
               int'(lut22_5[st_r.g6[4:0]]);
      end
      if (mode == MODE_RGB16)
        st_nxt.pix = {5'(rv), 6'(gv), 5'(bv)};
      else
        st_nxt.pix = {1'b0, 5'(rv), 5'(gv), 5'(bv)};
      if (qs.blank)
        st_nxt.pix = 16'h0000;
    end
    else
      st_nxt.pix = {st_r.y6, st_r.c6};

    // Line sync from the delayed leading qualifier
    qs = st_r.q[QN-1];
    st_nxt.hs_prev = st_r.hs_n;
    if (qs.lead && st_r.hse != 8'h00)
    begin
      st_nxt.hs_n = 1'b0;
      st_nxt.hs_cnt = 9'({st_r.hse, 1'b0} - 9'd1);
    end
    else if (!st_r.hs_n)
    begin
      if (st_r.hs_cnt == 9'h000)
        st_nxt.hs_n = 1'b1;
      else
        st_nxt.hs_cnt = st_r.hs_cnt - 9'h001;
    end

    // Serration accumulator
    if (!sync_low)
      st_nxt.acc = 12'h000;
    else if (st_r.acc != 12'hfff)
      st_nxt.acc = st_r.acc + 12'h001;
    fstart = src_locked ? (sync_low && st_r.acc == 12'(SERR_LOW_CYC - 1)) : int_fstart;
    eq_sel = src_locked ? eq_end : int_eq;
    // Odd field waits on trailing edge, even on leading edge
    hs_edge = st_r.fld ? (!st_r.hs_n && st_r.hs_prev) : (st_r.hs_n && !st_r.hs_prev);

    case (st_r.vs)
      VS_IDLE:
        if (fstart)
        begin
          st_nxt.fld = (src_locked && field_known) ? field_src : ~st_r.fld;
          st_nxt.vcnt = 3'(FS_GAP_CYC - 1);
          st_nxt.vs = VS_PRE;
        end
      VS_PRE:
        if (st_r.vcnt == 3'h0)
        begin
          st_nxt.vs_n = 1'b0;
          st_nxt.vs = VS_ACT;
        end
        else
          st_nxt.vcnt = st_r.vcnt - 3'h1;
      VS_ACT:
        if (eq_sel)
          st_nxt.vs = VS_EDGE;
      VS_EDGE:
        if (hs_edge)
        begin
          st_nxt.vcnt = 3'(FS_GAP_CYC - 2);
          st_nxt.vs = VS_POST;
        end
      VS_POST:
        if (st_r.vcnt == 3'h0)
        begin
          st_nxt.vs_n = 1'b1;
          st_nxt.vs = VS_IDLE;
        end
        else
          st_nxt.vcnt = st_r.vcnt - 3'h1;
      default:
        st_nxt.vs = VS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.fmt <= RST_FMT;
      st_r.hse <= RST_HSE;
      st_r.lctl <= RST_LCTL;
      st_r.cctl <= RST_CCTL;
      st_r.bri <= RST_BRI;
      st_r.con <= RST_CON;
      st_r.sat <= RST_SAT;
      st_r.hue <= RST_HUE;
      st_r.hs_n <= 1'b1;
      st_r.hs_prev <= 1'b1;
      st_r.vs_n <= 1'b1;
      st_r.vs <= VS_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign apb_rsp.prdata = st_r.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = st_r.pslverr;
  assign vout.pix = st_r.pix;
  assign vout.cr_phase = st_r.q[QN-1][0];
  assign vout.blank = st_r.q[QN-1][2];
  assign vout.vbi = st_r.q[QN-1][1];
  assign line_sync_n = st_r.hs_n;
  assign frame_sync_n = st_r.vs_n;
  assign field_out = st_r.fld;
  assign hue_phase = st_r.hue;

endmodule

// file: sim/vops_fb_sink.sv
// Frame buffer model: counts active (unblanked) pixels and line syncs.
// Assumes vout and line_sync_n are registered on mclk.
`timescale 1ns/1ps
module vops_fb_sink
  import vops_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Stream from the block
  input vops_pkg::vops_vout_type vout,
  input wire logic line_sync_n,
  // Capture counts
  output int pix_cnt,
  output int line_cnt
);
  logic ls_d = 1'b1;
  // Lines timed from line sync only, never from frame sync
  always_ff @(posedge mclk)
  begin
    ls_d <= line_sync_n;
    if (!vout.blank)
      pix_cnt <= pix_cnt + 1;
    if (ls_d && !line_sync_n)
      line_cnt <= line_cnt + 1;
  end
endmodule

// file: sim/vops_chk.sv
// Checker: sync timing, qualifier delay and forced pixel levels of vops_top.
// Sees top ports only; mirrors format and line sync end writes from APB.
`timescale 1ns/1ps
module vops_chk
  import vops_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Watched ports
  input vops_pkg::vops_apb_req_type apb_req,
  input vops_pkg::vops_vin_type vin,
  input wire logic src_locked,
  input vops_pkg::vops_vout_type vout,
  input wire logic line_sync_n,
  input wire logic frame_sync_n,
  input wire logic field_out
);
  logic [7:0] fmt_r;
  logic [7:0] hse_r;
  logic [8:0] low_r;
  logic [3:0] qt_r;
  logic wr;
  logic ycc;
  logic rgb;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  // Pipeline still holds old-format pixels for a while after a write
  // Internal timing makes its own blanking, so only locked input is compared
  assign ycc = qt_r == 4'hf && fmt_r[2:1] == PAT_NORMAL && fmt_r[4:3] < MODE_RGB15;
  assign rgb = qt_r == 4'hf && fmt_r[2:1] == PAT_NORMAL && fmt_r[4:3] >= MODE_RGB15;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fmt_r <= RST_FMT;
      hse_r <= RST_HSE;
      low_r <= '0;
      qt_r <= '0;
    end
    else
    begin
      low_r <= line_sync_n ? 9'h000 : low_r + 9'h001;
      qt_r <= ((wr && apb_req.paddr[11:2] == IDX_FMT) || !src_locked) ? 4'h0 :
        qt_r + {3'h0, qt_r != 4'hf};
      if (wr && apb_req.paddr[11:2] == IDX_FMT)
        fmt_r <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr[11:2] == IDX_HSE)
        hse_r <= apb_req.pwdata[7:0];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  chk_ls_lead: assert property ($fell(line_sync_n) && src_locked |->
    $past(vin.hsync_lead, 8)) else $error("line sync fell without lead");
  chk_ls_width: assert property ($rose(line_sync_n) |-> low_r == {hse_r, 1'b0})
    else $error("line sync width wrong");
  chk_fs_fall: assert property ($changed(field_out) |-> ##5 $fell(frame_sync_n))
    else $error("frame sync not 5 after field");
  chk_fs_rise: assert property ($rose(frame_sync_n) |->
    $past(line_sync_n, 5) != $past(line_sync_n, 6) && $past(line_sync_n, 5) == !field_out)
    else $error("frame sync end misplaced");
  chk_qual_delay: assert property (qt_r > 4'h8 |->
    vout.blank == $past(vin.blank, 7) && vout.vbi == $past(vin.vbi, 7) &&
    vout.cr_phase == $past(vin.cr_phase, 7))
    else $error("qualifier delay wrong");
  chk_blank_ycc: assert property (ycc && $past(vin.blank, 7) && !$past(vin.vbi, 7) |->
    vout.pix == 16'h1080) else $error("blank level wrong in YCbCr");
  chk_blank_rgb: assert property (rgb && $past(vin.blank, 7) |-> vout.pix == 16'h0000)
    else $error("blank level wrong in RGB");
  chk_ycc_clamp: assert property (ycc && !vout.blank && !vout.vbi |->
    vout.pix[15:8] inside {[8'h01:8'hfe]} && vout.pix[7:0] inside {[8'h01:8'hfe]})
    else $error("YCbCr sample outside clamp range");
  cov_fs: cover property ($fell(frame_sync_n));
  cov_ls: cover property ($rose(line_sync_n));
  cov_blank: cover property (rgb && vout.blank);
endmodule
bind vops_top vops_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req), .vin(vin),
  .src_locked(src_locked), .vout(vout), .line_sync_n(line_sync_n),
  .frame_sync_n(frame_sync_n), .field_out(field_out));

// file: sim/tb_video_output_processing_and_sync.sv
// Testbench: APB registers, pixel levels and formats, patterns, sync timing.
// Assumes vops_top answers APB at once and delays chroma by seven cycles and luma by eight.
`timescale 1ns/1ps
module tb_video_output_processing_and_sync;
  import vops_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  vops_apb_req_type req = '0;
  vops_apb_rsp_type rsp;
  vops_vin_type vin = '0;
  logic sync_low = 1'b0;
  logic eq_end = 1'b0;
  logic fknown = 1'b1;
  logic fsrc = 1'b0;
  logic lock = 1'b1;
  logic pal = 1'b0;
  logic f0;
  vops_vout_type vout;
  logic ls_n;
  logic fs_n;
  logic fld;
  logic [7:0] hue;
  logic [31:0] q;
  logic e;
  int err_count = 0;
  int total_checks = 0;
  int n;
  int lines;
  int pixels;
  always #2 mclk = ~mclk;
  // Default bar width keeps the whole short test line on the first bar
  vops_top #(.LINE_CYC(64), .FIELD_LINES(8), .ACTIVE_START(8), .ACTIVE_CYC(40),
    .SERR_LOW_CYC(16)) uut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .vin(vin), .src_locked(lock), .std_pal(pal), .sync_low(sync_low), .eq_end(eq_end),
    .field_known(fknown), .field_src(fsrc), .vout(vout), .line_sync_n(ls_n),
    .frame_sync_n(fs_n), .field_out(fld), .hue_phase(hue));
  vops_fb_sink sink (.mclk(mclk), .vout(vout), .line_sync_n(ls_n), .pix_cnt(pixels),
    .line_cnt(lines));
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1)
      @(posedge mclk);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 8'h00);
    `CHK(q, {24'h0, x})
    `CHK(e, xe)
  endtask
  task automatic px(input logic [9:0] y, input logic [7:0] c, input logic b, input logic cp,
    input logic [15:0] x);
    vin.luma <= y;
    vin.chroma <= c;
    vin.blank <= b;
    vin.cr_phase <= cp;
    repeat (12) @(posedge mclk);
    `CHK(vout.pix, x)
  endtask
  task automatic lsync(input logic [7:0] h, input int w);
    apb(1'b1, ad(IDX_HSE), h);
    vin.hsync_lead <= 1'b1;
    @(posedge mclk);
    vin.hsync_lead <= 1'b0;
    n = 0;
    repeat (540)
    begin
      @(negedge mclk);
      if (ls_n === 1'b0)
        n++;
    end
    `CHK(n, w)
    @(posedge mclk);
  endtask
  task automatic wfs(input logic v);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (fs_n !== v && n < 200);
    `CHK(fs_n, v)
    @(posedge mclk);
  endtask
  task automatic frame(input logic k, input logic s, input logic xf);
    fknown <= k;
    fsrc <= s;
    sync_low <= 1'b1;
    repeat (18) @(posedge mclk);
    sync_low <= 1'b0;
    wfs(1'b0);
    `CHK(fld, xf)
    eq_end <= 1'b1;
    @(posedge mclk);
    eq_end <= 1'b0;
    vin.hsync_lead <= 1'b1;
    @(posedge mclk);
    vin.hsync_lead <= 1'b0;
    wfs(1'b1);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(ad(IDX_FMT), RST_FMT, 1'b0);
    rd(ad(IDX_HSE), RST_HSE, 1'b0);
    rd(ad(IDX_CON), RST_CON, 1'b0);
    rd(ad(IDX_SAT), RST_SAT, 1'b0);
    rd(ad(IDX_STAT), 8'h08, 1'b0);
    rd(12'h200, 8'h00, 1'b1);
    apb(1'b1, ad(IDX_HUE), 8'h5a);
    `CHK(hue, 8'h5a)
    px(10'h040, 8'h80, 1'b0, 1'b0, 16'h1080);
    // Cr phase here leaves a neutral Cr held for the RGB tests
    px(10'h3ac, 8'h80, 1'b0, 1'b1, 16'heb80);
    px(10'h3ff, 8'hff, 1'b0, 1'b0, 16'hfefe);
    px(10'h000, 8'h00, 1'b0, 1'b0, 16'h0101);
    px(10'h3ac, 8'hc0, 1'b1, 1'b0, 16'h1080);
    vin.vbi <= 1'b1;
    px(10'h3ac, 8'h80, 1'b1, 1'b0, 16'heb80);
    vin.vbi <= 1'b0;
    for (int c = 1; c < 4; c++)
    begin
      apb(1'b1, ad(IDX_LCTL), 8'(c));
      apb(1'b1, ad(IDX_CCTL), 8'(c));
      px(10'(64 - 4 * c), 8'(128 - c), 1'b0, 1'b0, 16'h1080);
      apb(1'b1, ad(IDX_LCTL), 8'(c - 1));
      apb(1'b1, ad(IDX_CCTL), 8'(c - 1));
      px(10'(64 + 4 * c), 8'(128 + c), 1'b0, 1'b0, {8'(Y_OFFSET + c), 8'(C_ZERO + c)});
    end
    apb(1'b1, ad(IDX_LCTL), 8'h14);
    pal <= 1'b1;
    px(10'h3ac, 8'h80, 1'b0, 1'b0, 16'heb80);
    apb(1'b1, ad(IDX_LCTL), 8'h00);
    apb(1'b1, ad(IDX_CCTL), 8'h00);
    apb(1'b1, ad(IDX_BRI), 8'h10);
    px(10'h040, 8'h80, 1'b0, 1'b0, 16'h2080);
    apb(1'b1, ad(IDX_BRI), 8'h00);
    apb(1'b1, ad(IDX_CON), 8'h40);
    px(10'h1d0, 8'hc0, 1'b0, 1'b0, 16'h42c0);
    apb(1'b1, ad(IDX_CCTL), 8'(1 << CC_CON_BIT));
    px(10'h1d0, 8'hc0, 1'b0, 1'b0, 16'h42a0);
    apb(1'b1, ad(IDX_CON), RST_CON);
    apb(1'b1, ad(IDX_CCTL), 8'h00);
    apb(1'b1, ad(IDX_SAT), 8'h40);
    px(10'h040, 8'hc0, 1'b0, 1'b0, 16'h10a0);
    apb(1'b1, ad(IDX_SAT), RST_SAT);
    apb(1'b1, ad(IDX_FMT), 8'({MODE_RGB15, 3'b000}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, 16'h7fff);
    px(10'h040, 8'h80, 1'b0, 1'b0, 16'h0000);
    px(10'h3ac, 8'h80, 1'b1, 1'b0, 16'h0000);
    apb(1'b1, ad(IDX_FMT), 8'({2'b11, MODE_RGB15, 3'b000}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, 16'h7fff);
    apb(1'b1, ad(IDX_FMT), 8'({MODE_RGB16, 3'b000}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, 16'hffff);
    apb(1'b1, ad(IDX_FMT), 8'({PAT_BLUE, 1'b0}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, BLUE_CODE[23:8]);
    px(10'h3ac, 8'h80, 1'b0, 1'b1, {BLUE_CODE[23:16], BLUE_CODE[7:0]});
    apb(1'b1, ad(IDX_FMT), 8'({PAT_BLACK, 1'b0}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, BLACK_CODE[23:8]);
    apb(1'b1, ad(IDX_FMT), 8'({PAT_BARS, 1'b0}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, BAR_CODES[0][23:8]);
    apb(1'b1, ad(IDX_FMT), 8'({PAT_NORMAL, 1'b0}));
    px(10'h3ac, 8'h80, 1'b0, 1'b0, 16'heb80);
    lsync(8'h00, 0);
    lsync(8'hff, 510);
    lsync(8'h03, 6);
    `CHK(lines != 0, 1'b1)
    `CHK(pixels != 0, 1'b1)
    frame(1'b1, 1'b1, 1'b1);
    frame(1'b1, 1'b0, 1'b0);
    frame(1'b0, 1'b0, 1'b1);
    // Unlocked: one internal field start falls within 520 cycles
    f0 = fld;
    lock <= 1'b0;
    repeat (520) @(posedge mclk);
    `CHK(fld, ~f0)
    summarize();
  end
endmodule
